/* File: hdl/trace_trigger_regs.svh */
// register offsets, field positions and reset values of the trace trigger sequencer
// assumes a byte-addressed 8-bit apb address, one 32-bit word per register
`ifndef TRACE_TRIGGER_REGS_SVH
`define TRACE_TRIGGER_REGS_SVH

`define TTS_OFF_CTRL      8'h00
`define TTS_OFF_STATUS    8'h04
`define TTS_OFF_RANGE_LO  8'h08
`define TTS_OFF_RANGE_HI  8'h0C
`define TTS_OFF_TERM      8'h20
`define TTS_OFF_BRANCH    8'h40
`define TTS_OFF_FIND      8'h60

`define TTS_CTRL_RUN      0
`define TTS_CTRL_RESTART  1
`define TTS_CTRL_ARMRUN   2
`define TTS_CTRL_NLEV     4
`define TTS_CTRL_TRIG     8
`define TTS_TARGET_LSB    16
`define TTS_OCCUR_LSB     16

`define TTS_NLEV_RESET    4'h2
`define TTS_TRIG_RESET    4'h1
`define TTS_LEVELS_MIN    4'h2
`define TTS_LEVELS_MAX    4'h8
`define TTS_LEVELS_MAX_NR 4'h7

`endif

/* File: hdl/trace_trigger_pkg.sv */
// types shared by the trace trigger sequencer and its qualifier evaluator
// assumes nothing beyond a systemverilog compiler
package trace_trigger_pkg;

    typedef enum logic [1:0] {Q_NONE, Q_EVERY, Q_EXPR} qual_kind_e;

    // 16-bit qualifier word as software writes it, bit 15 reserved
    typedef struct packed {
        logic       spare;
        qual_kind_e kind;
        logic       comb_and;
        logic       g2_and;
        logic [3:0] g2_sel;
        logic       g1_and;
        logic [5:0] g1_sel;
    } qual_s;

    typedef struct packed {
        logic [15:0] care;
        logic [15:0] value;
    } term_s;

endpackage

/* File: hdl/qual_eval.sv */
// combinational evaluator of one two-group qualifier
// assumes term and range hits come from the same sample
`timescale 1ns/1ps
`default_nettype none

module qual_eval import trace_trigger_pkg::*; (
    // configuration
    input  wire qual_s      qual,
    // term hits of the current sample
    input  wire logic [7:0] term_hit,
    input  wire logic       inside_hit,
    input  wire logic       outside_hit,
    // result
    output logic            hit
);

    logic [5:0] g1_val;
    logic [3:0] g2_val;
    logic       g1_res;
    logic       g2_res;
    logic       g1_on;
    logic       g2_on;

    // and-mode uses inverted pattern terms only; range terms never invert
    assign g1_val = qual.g1_and ? {outside_hit, inside_hit, ~term_hit[3:0]}
                                : {outside_hit, inside_hit, term_hit[3:0]};
    assign g2_val = qual.g2_and ? ~term_hit[7:4] : term_hit[7:4];
    assign g1_on  = |qual.g1_sel;
    assign g2_on  = |qual.g2_sel;
    assign g1_res = qual.g1_and ? &(g1_val | ~qual.g1_sel)
                                : |(g1_val & qual.g1_sel);
    assign g2_res = qual.g2_and ? &(g2_val | ~qual.g2_sel)
                                : |(g2_val & qual.g2_sel);

    always_comb begin
        hit = 1'b0;
        case (qual.kind)
            Q_EVERY: hit = 1'b1;
            Q_NONE:  hit = 1'b0;
            Q_EXPR: begin
                // groups are combined as units, never by operator precedence
                if (g1_on && g2_on)
                    hit = qual.comb_and ? (g1_res & g2_res) : (g1_res | g2_res);
                else if (g1_on)
                    hit = g1_res;
                else
                    hit = g2_on & g2_res;
            end
            default: hit = 1'b0;
        endcase
    end

endmodule // qual_eval

`default_nettype wire

/* File: hdl/trace_trigger_sequencer.sv */
// multi-level state trace trigger sequencer with apb configuration
// assumes probe_clk and probe_data are asynchronous pins, stable for
// several pclk periods around each probe_clk rising edge
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "trace_trigger_regs.svh"

module trace_trigger_sequencer import trace_trigger_pkg::*; (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // probed target
    input  wire logic        probe_clk,
    input  wire logic [15:0] probe_data,
    // acquisition side
    output logic             store_force,
    output logic      [15:0] store_data,
    output logic             trigger_hit,
    output logic             running
);

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a[7] == 1'b0)
                  && ((a < 8'h10) || (a >= `TTS_OFF_TERM));
    endfunction

    // jump target must stay on the same side of the trigger level
    function automatic logic jump_ok(input logic [3:0] src, input logic [3:0] tgt,
                                     input logic [3:0] trig, input logic [3:0] nlev);
        if (src <= trig)
            jump_ok = (tgt >= 4'h1) && (tgt <= trig);
        else
            jump_ok = (tgt > trig) && (tgt <= nlev);
    endfunction

    // sampling of the probed state
    logic [1:0]  clk_sync;
    logic        clk_prev;
    logic [15:0] data_s1;
    logic [15:0] data_s2;
    logic        samp_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync <= 2'h0;
            clk_prev <= 1'b0;
            data_s1  <= 16'h0000;
            data_s2  <= 16'h0000;
        end else begin
            clk_sync <= {clk_sync[0], probe_clk};
            clk_prev <= clk_sync[1];
            data_s1  <= probe_data;
            data_s2  <= data_s1;
        end
    end

    assign samp_evt = clk_sync[1] & ~clk_prev;

    // configuration registers
    logic        run_reg;
    logic        restart_each_stage_reg;
    logic        arm_run_reg;
    logic [3:0]  nlev_reg;
    logic [3:0]  trig_reg;
    logic [15:0] range_lo_reg;
    logic [15:0] range_hi_reg;
    term_s       term_reg     [0:7];
    qual_s       branch_q_reg [0:7];
    logic [3:0]  target_reg   [0:7];
    qual_s       find_q_reg   [0:7];
    logic [15:0] occur_reg    [0:7];

    logic        wr_en;
    logic [2:0]  wr_idx;
    assign wr_en  = psel && penable && pwrite && addr_ok(paddr);
    assign wr_idx = paddr[4:2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg                <= 1'b0;
            restart_each_stage_reg <= 1'b0;
            arm_run_reg            <= 1'b1;
            nlev_reg               <= `TTS_NLEV_RESET;
            trig_reg               <= `TTS_TRIG_RESET;
            range_lo_reg           <= 16'h0000;
            range_hi_reg           <= 16'hFFFF;
        end else if (wr_en) begin
            if (paddr == `TTS_OFF_CTRL) begin
                run_reg                <= pwdata[`TTS_CTRL_RUN];
                restart_each_stage_reg <= pwdata[`TTS_CTRL_RESTART];
                arm_run_reg            <= pwdata[`TTS_CTRL_ARMRUN];
                nlev_reg               <= pwdata[`TTS_CTRL_NLEV +: 4];
                trig_reg               <= {1'b0, pwdata[`TTS_CTRL_TRIG +: 3]};
            end
            if (paddr == `TTS_OFF_RANGE_LO)
                range_lo_reg <= pwdata[15:0];
            if (paddr == `TTS_OFF_RANGE_HI)
                range_hi_reg <= pwdata[15:0];
        end
    end

    // per-term and per-level tables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                term_reg[i]     <= '0;
                branch_q_reg[i] <= '0;
                target_reg[i]   <= 4'h1;
                find_q_reg[i]   <= '0;
                occur_reg[i]    <= 16'h0001;
            end
        end else if (wr_en) begin
            case (paddr[7:5])
                3'h1: term_reg[wr_idx] <= pwdata;
                3'h2: begin
                    branch_q_reg[wr_idx] <= qual_s'({1'b0, pwdata[14:0]});
                    target_reg[wr_idx]   <= pwdata[`TTS_TARGET_LSB +: 4];
                end
                3'h3: begin
                    find_q_reg[wr_idx] <= qual_s'({1'b0, pwdata[14:0]});
                    occur_reg[wr_idx]  <= pwdata[`TTS_OCCUR_LSB +: 16];
                end
                default: ;
            endcase
        end
    end

    // run control; a start with an illegal level layout is refused
    logic cfg_legal;
    logic running_reg;
    logic run_start;

    assign cfg_legal = (nlev_reg >= `TTS_LEVELS_MIN)
                       && (nlev_reg <= (arm_run_reg ? `TTS_LEVELS_MAX
                                                    : `TTS_LEVELS_MAX_NR))
                       && (trig_reg >= 4'h1) && (trig_reg < nlev_reg);
    assign run_start = run_reg && cfg_legal && !running_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            running_reg <= 1'b0;
        else
            running_reg <= run_reg && cfg_legal;
    end

    // term evaluation
    logic [7:0] term_hit;
    logic       inside_hit;
    logic       outside_hit;

    always_comb begin
        for (int i = 0; i < 8; i++)
            term_hit[i] = ((data_s2 ^ term_reg[i].value) & term_reg[i].care) == 16'h0000;
    end

    assign inside_hit  = (data_s2 >= range_lo_reg) && (data_s2 <= range_hi_reg);
    assign outside_hit = !inside_hit;

    // qualifiers of the current level
    logic [3:0]  level_reg;
    logic [2:0]  lvl_idx;
    logic        branch_hit;
    logic        find_hit;
    logic [3:0]  branch_tgt;
    logic [15:0] occ_eff;

    assign lvl_idx    = 3'(level_reg - 4'h1);
    assign branch_tgt = target_reg[lvl_idx];
    assign occ_eff    = (occur_reg[lvl_idx] == 16'h0000) ? 16'h0001 : occur_reg[lvl_idx];

    qual_eval u_branch_eval (
        .qual        (branch_q_reg[lvl_idx]),
        .term_hit    (term_hit),
        .inside_hit  (inside_hit),
        .outside_hit (outside_hit),
        .hit         (branch_hit)
    );

    qual_eval u_find_eval (
        .qual        (find_q_reg[lvl_idx]),
        .term_hit    (term_hit),
        .inside_hit  (inside_hit),
        .outside_hit (outside_hit),
        .hit         (find_hit)
    );

    // sequencing; proceed has priority over a jump on the same sample
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [3:0]  level_next;
    logic        proceed_fire;
    logic        branch_take;
    logic        lvl_change;

    assign proceed_fire = samp_evt && running_reg && find_hit
                          && (16'(cnt_reg + 16'h0001) == occ_eff);
    assign branch_take  = samp_evt && running_reg && restart_each_stage_reg
                          && branch_hit && !proceed_fire
                          && jump_ok(level_reg, branch_tgt, trig_reg, nlev_reg);

    always_comb begin
        level_next = level_reg;
        if (run_start)
            level_next = 4'h1;
        else if (proceed_fire && (level_reg < nlev_reg))
            level_next = level_reg + 4'h1;
        else if (branch_take)
            level_next = branch_tgt;
    end

    always_comb begin
        cnt_next = cnt_reg;
        if (run_start || proceed_fire || branch_take)
            cnt_next = 16'h0000;
        else if (samp_evt && running_reg && find_hit)
            cnt_next = 16'(cnt_reg + 16'h0001);
    end

    assign lvl_change = samp_evt && running_reg && (level_next != level_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= 4'h1;
            cnt_reg   <= 16'h0000;
        end else begin
            level_reg <= level_next;
            cnt_reg   <= cnt_next;
        end
    end

    // forced store of the level-changing sample and trigger flag
    logic        store_force_reg;
    logic [15:0] store_data_reg;
    logic        trigger_reg;
    logic        triggered_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_force_reg <= 1'b0;
            store_data_reg  <= 16'h0000;
        end else begin
            store_force_reg <= lvl_change;
            if (lvl_change)
                store_data_reg <= data_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_reg   <= 1'b0;
            triggered_reg <= 1'b0;
        end else begin
            trigger_reg <= proceed_fire && (level_reg == trig_reg);
            if (proceed_fire && (level_reg == trig_reg))
                triggered_reg <= 1'b1;
            else if (run_start)
                triggered_reg <= 1'b0;
        end
    end

    assign store_force = store_force_reg;
    assign store_data  = store_data_reg;
    assign trigger_hit = trigger_reg;
    assign running     = running_reg;

    // apb read path: data is latched in the setup cycle so access needs no wait
    logic [31:0] rd_word;
    logic [31:0] prdata_reg;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr[7:5])
            3'h0: begin
                case (paddr[4:2])
                    3'h0: rd_word = {21'h0, trig_reg[2:0], nlev_reg, 1'b0,
                                     arm_run_reg, restart_each_stage_reg, run_reg};
                    3'h1: rd_word = {cnt_reg, 9'h0, !cfg_legal, triggered_reg,
                                     running_reg, level_reg};
                    3'h2: rd_word = {16'h0000, range_lo_reg};
                    3'h3: rd_word = {16'h0000, range_hi_reg};
                    default: rd_word = 32'h0000_0000;
                endcase
            end
            3'h1: rd_word = term_reg[paddr[4:2]];
            3'h2: rd_word = {12'h000, target_reg[paddr[4:2]],
                             16'(branch_q_reg[paddr[4:2]])};
            3'h3: rd_word = {occur_reg[paddr[4:2]], 16'(find_q_reg[paddr[4:2]])};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_reg <= addr_ok(paddr) ? rd_word : 32'h0000_0000;
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_jump_target: assert property (branch_take |=> level_reg == $past(branch_tgt))
        else $error("jump did not land on the configured target");

    chk_jump_gated: assert property (
        (!restart_each_stage_reg && !proceed_fire && !run_start) |=> $stable(level_reg))
        else $error("level moved by a jump outside per-level restart mode");

    chk_jump_side: assert property (
        branch_take |-> ((level_reg <= trig_reg) == (branch_tgt <= trig_reg)))
        else $error("jump crossed the trigger level");

    chk_level_count: assert property (
        $rose(running_reg) |-> (nlev_reg >= 4'h2)
                               && (nlev_reg <= (arm_run_reg ? 4'h8 : 4'h7)))
        else $error("run started with an illegal level count");

    // running follows the layout one cycle late, so it is held against the layout it was granted on
    chk_trig_below: assert property (
        running_reg |-> (level_reg <= $past(nlev_reg)) && ($past(trig_reg) >= 4'h1)
                        && ($past(trig_reg) < $past(nlev_reg)))
        else $error("trigger or current level out of range while running");

    chk_occur_count: assert property (
        proceed_fire |-> (cnt_reg == 16'(occ_eff - 16'h0001)))
        else $error("proceed fired at the wrong occurrence");

    chk_range_terms: assert property (
        (data_s2 < range_lo_reg) |-> (outside_hit && !inside_hit))
        else $error("sample below range not flagged outside");

    chk_advance_step: assert property (
        (proceed_fire && (level_reg < nlev_reg)) |=> level_reg == $past(level_reg) + 4'h1)
        else $error("proceed did not advance one level");

    chk_trigger_pulse: assert property (
        (proceed_fire && (level_reg == trig_reg)) |=> trigger_hit ##1 !trigger_hit)
        else $error("trigger pulse missing or too long");

    chk_store_change: assert property (
        ($past(running_reg) && running_reg && (level_reg != $past(level_reg)))
        |-> store_force && (store_data == $past(data_s2)))
        else $error("level change sample was not forced to store");

    chk_every_sample: assert property (
        (find_q_reg[lvl_idx].kind == Q_EVERY) |-> find_hit)
        else $error("match-every-sample qualifier missed");

    chk_change_timing: assert property (
        ($past(running_reg) && (level_reg != $past(level_reg))) |-> $past(samp_evt))
        else $error("level changed without a sample");

    cov_jump:    cover property (branch_take ##1 store_force);
    cov_trigger: cover property (trigger_hit);
    cov_run:     cover property ($rose(running_reg));
    cov_refused: cover property (run_reg && !cfg_legal);

endmodule // trace_trigger_sequencer

`default_nettype wire

/* File: dv/probe_target.sv */
// behavioural target system: one state clock rise for each sample the bench asks for
// assumes the sequencer reads the probe pins through its own synchronisers
`timescale 1ns/1ps
`default_nettype none

module probe_target (
    // bench clock
    input  wire logic        pclk,
    // target pins
    output logic             probe_clk,
    output logic      [15:0] probe_data
);
    initial begin
        probe_clk  = 1'b0;
        probe_data = 16'h0000;
    end

    // data held from one edge before the rise to six after it, then inverted
    // so that a late sample never sees a stale copy; the clock rests low between frames
    task automatic send(input logic [15:0] v);
        @(posedge pclk);
        probe_data <= v;
        @(posedge pclk);
        probe_clk <= 1'b1;
        repeat (3) @(posedge pclk);
        probe_clk <= 1'b0;
        repeat (3) @(posedge pclk);
        probe_data <= ~v;
    endtask
endmodule // probe_target

`default_nettype wire

/* File: dv/tb_trace_trigger_sequencer.sv */
// self-checking bench of the trace trigger sequencer over apb and the probe pins
// assumes probe_target drives the probe pins and the design answers apb at once
`timescale 1ns/1ps
`default_nettype none

module tb_trace_trigger_sequencer import trace_trigger_pkg::*;;
    logic             pclk;
    logic             presetn;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic      [7:0]  paddr;
    logic      [31:0] pwdata;
    wire logic [31:0] prdata;
    wire logic        pready;
    wire logic        pslverr;
    wire logic        probe_clk;
    wire logic [15:0] probe_data;
    wire logic        store_force;
    wire logic [15:0] store_data;
    wire logic        trigger_hit;
    wire logic        running;
    int               mismatches;
    int               n_compared;
    int               n_store;
    int               n_trig;
    logic      [15:0] last_store;

    trace_trigger_sequencer trace_trigger_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .probe_clk(probe_clk),
        .probe_data(probe_data), .store_force(store_force), .store_data(store_data),
        .trigger_hit(trigger_hit), .running(running)
    );
    probe_target probe_target_i (.pclk(pclk), .probe_clk(probe_clk), .probe_data(probe_data));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // pulses stand one cycle, so they are counted where they appear
    always @(posedge pclk) begin
        if (store_force === 1'b1) begin
            n_store++;
            last_store <= store_data;
        end
        if (trigger_hit === 1'b1)
            n_trig++;
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, a, 32'h0000_0000, r, e);
        check32(r & m, x, "register read");
    endtask

    // stop first so that the new start re-enters level 1
    task automatic start(input logic [31:0] ctrl);
        wr(8'h00, ctrl & 32'hFFFF_FFFE);
        wr(8'h00, ctrl);
    endtask

    task automatic t_reset();
        rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0124);
        rd_chk(8'h04, 32'h0000_007F, 32'h0000_0001);
        rd_chk(8'h0C, 32'h0000_FFFF, 32'h0000_FFFF);
        rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0001_0000);
        rd_chk(8'h7C, 32'hFFFF_FFFF, 32'h0001_0000);
    endtask

    task automatic t_access();
        logic [31:0] r;
        logic        e;
        xfer(1'b0, 8'h10, 32'h0000_0000, r, e);
        check32({r[30:0], e}, 32'h0000_0001, "unmapped read");
        wr(8'h04, 32'h0000_00FF);
        rd_chk(8'h04, 32'h0000_007F, 32'h0000_0001);
        wr(8'h48, 32'h0003_D883);
        rd_chk(8'h48, 32'hFFFF_FFFF, 32'h0003_5883);
    endtask

    task automatic t_jump();
        int s0;
        s0 = n_store;
        wr(8'h40, 32'h0002_2000);
        start(32'h0000_0245);
        probe_target_i.send(16'h0001);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0011);
        start(32'h0000_0247);
        probe_target_i.send(16'h0002);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0012);
        check32(n_store - s0, 32'd1, "store pulses after jump");
        // level 3 lies past trigger level 2, so this jump must be dropped
        wr(8'h44, 32'h0003_2000);
        probe_target_i.send(16'h0003);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0012);
        wr(8'h44, 32'h0001_2000);
        probe_target_i.send(16'h0004);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0011);
        check32(last_store, 32'h0000_0004, "stored jump sample");
    endtask

    task automatic t_proceed();
        int t0;
        t0 = n_trig;
        wr(8'h60, 32'h0002_2000);
        wr(8'h64, 32'h0001_2000);
        start(32'h0000_0235);
        probe_target_i.send(16'h00A1);
        rd_chk(8'h04, 32'hFFFF_003F, 32'h0001_0011);
        probe_target_i.send(16'h00A2);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0012);
        check32(last_store, 32'h0000_00A2, "stored proceed sample");
        probe_target_i.send(16'h00A3);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0033);
        probe_target_i.send(16'h00A4);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0033);
        check32(n_trig - t0, 32'd1, "trigger pulses");
    endtask

    // (A or B) and (not E): grouping decides, not operator precedence
    task automatic t_expr();
        int t0;
        t0 = n_trig;
        wr(8'h20, 32'hFFFF_1234);
        wr(8'h24, 32'h00FF_00FF);
        wr(8'h30, 32'h0F00_0F00);
        wr(8'h60, 32'h0001_5883);
        start(32'h0000_0125);
        probe_target_i.send(16'h0FFF);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0011);
        probe_target_i.send(16'h00FF);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0032);
        check32(n_trig - t0, 32'd1, "expression trigger");
    endtask

    // window 0x100..0x1FF with inclusive bounds; level 2 waits for (not A) and inside
    task automatic t_range();
        int s0;
        s0 = n_store;
        wr(8'h08, 32'h0000_0100);
        wr(8'h0C, 32'h0000_01FF);
        wr(8'h60, 32'h0001_4020);
        wr(8'h64, 32'h0001_4051);
        start(32'h0000_0135);
        probe_target_i.send(16'h0150);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0011);
        probe_target_i.send(16'h0200);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0032);
        probe_target_i.send(16'h00FF);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0032);
        probe_target_i.send(16'h01FF);
        rd_chk(8'h04, 32'h0000_003F, 32'h0000_0033);
        check32(n_store - s0, 32'd2, "range level changes");
    endtask

    // reset in mid-run must bring every register and the level back to its reset value
    task automatic t_midreset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check32({31'h0, running}, 32'h0000_0000, "running after reset");
        rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0124);
        rd_chk(8'h04, 32'hFFFF_007F, 32'h0000_0001);
        rd_chk(8'h64, 32'hFFFF_FFFF, 32'h0001_0000);
    endtask

    task automatic t_illegal();
        start(32'h0000_0181);
        rd_chk(8'h04, 32'h0000_0050, 32'h0000_0040);
        start(32'h0000_0185);
        rd_chk(8'h04, 32'h0000_0050, 32'h0000_0010);
        start(32'h0000_0335);
        check32({31'h0, running}, 32'h0000_0000, "running with bad trigger level");
    endtask

    initial begin
        #(40 * 40000);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_access();
        t_jump();
        t_proceed();
        t_expr();
        t_range();
        t_midreset();
        t_illegal();
        tally_and_finish();
    end
endmodule // tb_trace_trigger_sequencer

`default_nettype wire
